// [hcf_pkg.sv]
// hcf_pkg: constants and types for the host command FIFO front end.
// assumes a 32-bit APB slave on one 250 MHz clock.
package hcf_pkg;
    localparam int          ADDR_W     = 14;
    localparam int          DATA_W     = 32;
    localparam int          FIFO_DEPTH = 16;
    localparam int          FIFO_AW    = 4;
    localparam int          CNT_W      = 5;
    localparam int          REG_N      = 64;
    localparam int          ID_W       = 6;
    localparam int          BCNT_W     = 14;
    // register byte offsets
    localparam logic [13:0] OFF_CTRL    = 14'h0000;
    localparam logic [13:0] OFF_FREE    = 14'h0004;
    localparam logic [13:0] OFF_DMA_ADR = 14'h0008;
    localparam logic [13:0] OFF_DMA_CNT = 14'h000C;
    localparam logic [13:0] OFF_STATUS  = 14'h0010;
    localparam logic [13:0] FIFO_LO     = 14'h2000;
    localparam logic [13:0] FIFO_HI     = 14'h2FFF;
    // control fields and reset value
    localparam int          CTRL_DISC   = 0;
    localparam int          CTRL_LBWI   = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    // header word layout: [31:30] format, [29:16] count, [5:0] register id
    localparam int          HDR_FMT     = 30;
    localparam int          HDR_CNT     = 16;
    localparam logic [1:0]  FMT_BASIC   = 2'h0;
    localparam logic [1:0]  FMT_INDEX   = 2'h1;
    localparam logic [1:0]  FMT_HOLD    = 2'h2;
    localparam logic [13:0] GROUP_SIZE  = 14'h0004;
    // command and special register ids
    localparam logic [5:0]  ID_START    = 6'h10;
    localparam logic [5:0]  ID_RENDER   = 6'h20;
    localparam logic [5:0]  ID_LINE     = 6'h21;
    localparam logic [5:0]  ID_DOM      = 6'h22;
    localparam logic [5:0]  ID_SYNC     = 6'h23;
    typedef enum logic [2:0] {DEC_HEAD = 3'b001, DEC_DATA = 3'b010, DEC_SYNC = 3'b100} hcf_dec_t;
    typedef enum logic [2:0] {DMA_IDLE = 3'b001, DMA_FETCH = 3'b010, DMA_PUSH = 3'b100} hcf_dma_t;
    typedef enum logic [1:0] {CMD_RENDER = 2'h0, CMD_LINE = 2'h1, CMD_DOM = 2'h2} hcf_cmd_t;
endpackage

// [hcf_fifo_if.sv]
// hcf_fifo_if: push and pop sides of the command FIFO.
// assumes both ends run on mclk.
`timescale 1ns/100ps
interface hcf_fifo_if;
    logic        push;
    logic [31:0] pushData;
    logic        pop;
    logic [31:0] popData;
    logic        full;
    logic        empty;
    logic [4:0]  freeCount;
    modport owner (input push, pushData, pop, output popData, full, empty, freeCount);
    modport user  (output push, pushData, pop, input popData, full, empty, freeCount);
endinterface

// [hcf_cmd_fifo.sv]
// hcf_cmd_fifo: show-ahead command FIFO with free-entry count.
// assumes push is never raised while full and pop never while empty.
`timescale 1ns/100ps
module hcf_cmd_fifo
    import hcf_pkg::*;
(
    input wire logic mclk,  // clock
    input wire logic rst_n, // synchronous reset, low
    input wire logic ce,    // clock enable
    hcf_fifo_if.owner f     // fifo ports
);
    logic [31:0]      mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wrPtr;
    logic [FIFO_AW-1:0] rdPtr;
    logic [CNT_W-1:0]   used;
    wire              doPush = f.push & ~f.full;
    wire              doPop  = f.pop & ~f.empty;

    // flags from the fill level
    assign f.full      = (used == CNT_W'(FIFO_DEPTH));
    assign f.empty     = (used == '0);
    assign f.freeCount = CNT_W'(FIFO_DEPTH) - used; // R22
    assign f.popData   = mem[rdPtr];

    // pointers and fill level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            used  <= '0;
        end else if (ce) begin
            if (doPush) wrPtr <= wrPtr + 1'b1;
            if (doPop) rdPtr <= rdPtr + 1'b1;
            used <= used + CNT_W'(doPush) - CNT_W'(doPop); // R22
        end
    end

    // storage has no reset
    always_ff @(posedge mclk) begin
        if (ce && doPush) mem[wrPtr] <= f.pushData;
    end

    a_free_bound : assert property (@(posedge mclk) disable iff (!rst_n)
        f.freeCount <= CNT_W'(FIFO_DEPTH)) else $error("free count above depth"); // R22
endmodule // hcf_cmd_fifo

// [hcf_front_end.sv]
// hcf_front_end: APB-fed command FIFO, DMA loader and command decoder.
// assumes an APB master on mclk; DMA memory answers on the same clock.
// Operation
// R1 - whole alias window writes the FIFO port; here only word-aligned addresses hit it, others end with pslverr
// R2 - host bursts ascending by four bytes
// R3 - full FIFO stalls write, data kept
// R4 - host repeats stalled write until taken
// R5 - free entry count is readable
// R6 - basic format carries id and value
// R7 - indexed header loads a register group
// R8 - hold header streams words to one register
// R9 - DMA pushes fetched words into FIFO
// R10 - DMA completion raises interrupt
// R11 - loaded registers persist across primitives
// R12 - render redraws with stored clip values
// R13 - continue resumes from stored edge state
// R14 - software keeps render and continues atomic
// R15 - no write-read ordering across continue
// R16 - sync drains pending writes before reads
// R17 - inhibit bit stops local buffer writes
// R18 - software disables unused units
// R19 - software loads command register last
// R20 - software drains the output FIFO
// R21 - stall option bit; else full drops data
// R22 - free count tracks pushes and pops
`timescale 1ns/100ps
module hcf_front_end (
    input  wire logic                  mclk,             // 250 MHz clock
    input  wire logic                  rst_n,            // synchronous reset, low
    input  wire logic                  ce,               // freezes state when low
    input  wire logic                  psel,             // APB select
    input  wire logic                  penable,          // APB enable
    input  wire logic                  pwrite,           // APB write
    input  wire logic [hcf_pkg::ADDR_W-1:0] paddr,       // APB byte address
    input  wire logic [31:0]           pwdata,           // APB write data
    output logic      [31:0]           prdata,           // APB read data
    output logic                       pready,           // APB ready
    output logic                       pslverr,          // unmapped access
    output logic                       dmaReq,           // DMA word fetch request
    output logic      [31:0]           dmaAddr,          // DMA fetch address
    input  wire logic                  dmaAck,           // fetch answered
    input  wire logic [31:0]           dmaData,          // fetched word
    output logic                       dmaIrq,           // DMA done, level
    output logic                       cmdStrobe,        // command pulse
    output hcf_pkg::hcf_cmd_t          cmdKind,          // command type
    output logic                       cmdUseEdge,       // resume from edge state
    output logic      [31:0]           cmdEdgeStart,     // edge start value
    output logic                       syncHold,         // draining writes
    input  wire logic                  memWritesPending, // writes not yet in memory
    output logic                       lbWriteInhibit,   // no local buffer writes
    input  wire logic [hcf_pkg::ID_W-1:0] regSel,        // register read select
    output logic      [31:0]           regValue          // selected register
);
    import hcf_pkg::*;

    hcf_fifo_if f ();
    hcf_cmd_fifo uFifo (.mclk(mclk), .rst_n(rst_n), .ce(ce), .f(f));

    logic [1:0]        ctrl;
    logic              accept;
    logic [BCNT_W-1:0] dmaCount;
    logic [31:0]       dmaWord;
    hcf_dma_t          dmaState;
    hcf_dec_t          decState;
    logic [1:0]        decFmt;
    logic [ID_W-1:0]   decId;
    logic [BCNT_W-1:0] decCount;
    logic [31:0]       regs [REG_N];
    logic [31:0]       edgeState;

    // APB decode
    wire access   = psel & penable;
    wire aligned  = (paddr[1:0] == 2'h0);
    wire fifoHit  = (paddr >= FIFO_LO) && (paddr <= FIFO_HI) && aligned; // R1
    wire hitCtrl  = (paddr == OFF_CTRL);
    wire hitFree  = (paddr == OFF_FREE);
    wire hitAdr   = (paddr == OFF_DMA_ADR);
    wire hitCnt   = (paddr == OFF_DMA_CNT);
    wire hitStat  = (paddr == OFF_STATUS);
    wire mapped   = fifoHit | hitCtrl | hitFree | hitAdr | hitCnt | hitStat;
    wire fifoWr   = access & pwrite & fifoHit;
    wire stallFul = fifoWr & f.full & ctrl[CTRL_DISC]; // R3 R21
    wire apbDone  = access & pready;
    wire regWr    = apbDone & pwrite;
    wire next_pready = access & ~pready & ~stallFul;
    wire [31:0] statusWord = {24'h0, decState, dmaState, syncHold, dmaIrq};
    wire [31:0] readMux =
        hitCtrl ? {30'h0, ctrl} :
        hitFree ? {27'h0, f.freeCount} : // R5
        hitAdr  ? dmaAddr :
        hitCnt  ? {18'h0, dmaCount} :
        hitStat ? statusWord : 32'h0;

    // a write to a full FIFO with stalling off finishes and is dropped
    wire apbPush = regWr & fifoHit & accept; // R1 R21
    wire dmaPush = (dmaState == DMA_PUSH) & ~f.full & ~fifoWr; // R9
    wire dmaLast = (dmaCount == BCNT_W'(1));
    wire dmaStart = regWr & hitCnt & (dmaState == DMA_IDLE) & (pwdata[BCNT_W-1:0] != '0);

    // decoder selection
    wire decPop   = ~f.empty & ((decState == DEC_HEAD) | (decState == DEC_DATA));
    wire headPop  = decPop & (decState == DEC_HEAD);
    wire dataPop  = decPop & (decState == DEC_DATA);
    wire [1:0] hdrFmt = f.popData[HDR_FMT+1:HDR_FMT];
    wire [BCNT_W-1:0] hdrCnt = f.popData[HDR_CNT+BCNT_W-1:HDR_CNT];
    wire [BCNT_W-1:0] next_count = (hdrFmt == FMT_HOLD) ? hdrCnt :
                                   (hdrFmt == FMT_INDEX) ? GROUP_SIZE : BCNT_W'(1); // R6 R7 R8
    wire [ID_W-1:0] next_id = (hdrFmt == FMT_INDEX) ? {f.popData[3:0], 2'h0} :
                              f.popData[ID_W-1:0]; // R7
    wire isRender = (decId == ID_RENDER);
    wire isCmd    = isRender | (decId == ID_LINE) | (decId == ID_DOM);
    wire isSync   = (decId == ID_SYNC);
    wire lastWord = (decCount == BCNT_W'(1));

    assign f.push     = apbPush | dmaPush; // R9
    assign f.pushData = apbPush ? pwdata : dmaWord;
    assign f.pop      = decPop;

    // APB answer; a stalled full write keeps pready low until space frees
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            accept  <= 1'b0;
        end else if (ce) begin
            pready <= next_pready; // R3
            if (next_pready) begin
                pslverr <= ~mapped;
                prdata  <= pwrite ? 32'h0 : readMux;
                accept  <= ~f.full; // R21
            end
        end
    end

    // software control bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl           <= CTRL_RST;
            lbWriteInhibit <= 1'b0;
        end else if (ce) begin
            if (regWr && hitCtrl) ctrl <= pwdata[1:0];
            lbWriteInhibit <= ctrl[CTRL_LBWI]; // R17
        end
    end

    // DMA loader: one outstanding fetch, then a push that waits for room
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dmaState <= DMA_IDLE;
            dmaReq   <= 1'b0;
            dmaAddr  <= 32'h0;
            dmaCount <= '0;
            dmaWord  <= 32'h0;
            dmaIrq   <= 1'b0;
        end else if (ce) begin
            case (dmaState)
                DMA_IDLE: begin
                    if (regWr && hitAdr) dmaAddr <= pwdata;
                    if (regWr && hitCnt) dmaIrq <= 1'b0;
                    if (dmaStart) begin
                        dmaCount <= pwdata[BCNT_W-1:0];
                        dmaReq   <= 1'b1;
                        dmaState <= DMA_FETCH;
                    end
                end
                DMA_FETCH: begin
                    if (dmaAck) begin
                        dmaWord  <= dmaData;
                        dmaReq   <= 1'b0;
                        dmaState <= DMA_PUSH;
                    end
                end
                DMA_PUSH: begin
                    if (dmaPush) begin // R9
                        dmaAddr  <= dmaAddr + 32'h4;
                        dmaCount <= dmaCount - BCNT_W'(1);
                        if (dmaLast) begin
                            dmaIrq   <= 1'b1; // R10
                            dmaState <= DMA_IDLE;
                        end else begin
                            dmaReq   <= 1'b1;
                            dmaState <= DMA_FETCH;
                        end
                    end
                end
                default: dmaState <= DMA_IDLE;
            endcase
        end
    end

    // command decoder; a sync word parks it until writes have drained
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            decState <= DEC_HEAD;
            decFmt   <= FMT_BASIC;
            decId    <= '0;
            decCount <= '0;
            syncHold <= 1'b0;
        end else if (ce) begin
            case (decState)
                DEC_HEAD: begin
                    if (headPop) begin
                        decFmt   <= hdrFmt;
                        decId    <= next_id;
                        decCount <= next_count;
                        if (next_count != '0) decState <= DEC_DATA;
                    end
                end
                DEC_DATA: begin
                    if (dataPop) begin
                        decCount <= decCount - BCNT_W'(1);
                        if (decFmt == FMT_INDEX) decId <= decId + 1'b1; // R7
                        if (isSync) begin
                            syncHold <= 1'b1; // R16
                            decState <= DEC_SYNC;
                        end else if (lastWord) begin
                            decState <= DEC_HEAD;
                        end
                    end
                end
                DEC_SYNC: begin
                    if (!memWritesPending) begin // R16
                        syncHold <= 1'b0;
                        decState <= (decCount == '0) ? DEC_HEAD : DEC_DATA;
                    end
                end
                default: decState <= DEC_HEAD;
            endcase
        end
    end

    // register file: values stay until rewritten, so a render reuses them
    always_ff @(posedge mclk) begin
        if (ce && dataPop) regs[decId] <= f.popData; // R6 R8 R11 R12
    end

    // command issue; continues skip any ordering wait, only sync gives one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmdStrobe    <= 1'b0;
            cmdKind      <= CMD_RENDER;
            cmdUseEdge   <= 1'b0;
            cmdEdgeStart <= 32'h0;
            edgeState    <= 32'h0;
            regValue     <= 32'h0;
        end else if (ce) begin
            cmdStrobe <= dataPop & isCmd; // R15
            regValue  <= regs[regSel];
            if (dataPop && isCmd) begin
                cmdKind    <= hcf_cmd_t'(decId[1:0]);
                cmdUseEdge <= ~isRender; // R13
                if (isRender) begin
                    edgeState    <= regs[ID_START]; // R12
                    cmdEdgeStart <= regs[ID_START];
                end else begin
                    cmdEdgeStart <= edgeState; // R13
                end
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_full_write;
        fifoWr && f.full && ctrl[CTRL_DISC];
    endsequence
    sequence s_drop_write;
        access && !pready && pwrite && fifoHit && f.full && !ctrl[CTRL_DISC];
    endsequence

    a_stall_full : assert property (s_full_write |=> !pready) // R3
        else $error("full write was answered");
    a_drop_done : assert property (s_drop_write |=> pready ##0 !f.push) // R21
        else $error("dropped write not finished");
    a_alias_push : assert property (apbDone && pwrite && fifoHit && accept |-> f.push) // R1
        else $error("alias write not pushed");
    a_free_read : assert property (access && !pready && !pwrite && hitFree
        |=> prdata == {27'h0, $past(f.freeCount)}) // R5
        else $error("free count read wrong");
    a_sync_hold : assert property (decState == DEC_SYNC && memWritesPending |-> !f.pop ##0 syncHold) // R16
        else $error("decoder ran during sync");
    a_lb_inhibit : assert property (ctrl[CTRL_LBWI] ##1 ctrl[CTRL_LBWI] |-> lbWriteInhibit) // R17
        else $error("inhibit not shown");
    a_cont_edge : assert property (cmdStrobe && cmdKind != CMD_RENDER
        |-> cmdUseEdge && cmdEdgeStart == edgeState) // R13
        else $error("continue lost edge state");
    a_dma_done : assert property (dmaPush && dmaLast |=> dmaIrq && dmaState == DMA_IDLE) // R10
        else $error("dma end not flagged");
    a_dma_push : assert property (dmaState == DMA_FETCH && dmaAck |=> dmaState == DMA_PUSH ##0 !dmaReq) // R9
        else $error("dma word not staged");
endmodule // hcf_front_end

// [hcf_mem_model.sv]
// hcf_mem_model: host memory answering the block's DMA word fetches.
// assumes one fetch outstanding at a time; gap sets wait cycles per word.
`timescale 1ns/100ps
module hcf_mem_model (
    input  wire logic        mclk,    // clock
    input  wire logic        rst_n,   // synchronous reset, low
    input  wire logic        dmaReq,  // fetch request
    input  wire logic [31:0] dmaAddr, // fetch address
    input  wire logic [1:0]  gap,     // answer delay
    output logic             dmaAck,  // word valid pulse
    output logic      [31:0] dmaData  // fetched word
);
    logic [31:0] mem [16];
    logic [1:0]  waitCnt;
    // released data bus is inverted so a stale word can never pass as fresh
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dmaAck  <= 1'b0;
            dmaData <= 32'h0;
            waitCnt <= 2'h0;
        end else if (dmaAck) begin
            dmaAck  <= 1'b0;
            dmaData <= ~dmaData;
            waitCnt <= 2'h0;
        end else if (dmaReq && waitCnt == gap) begin
            dmaAck  <= 1'b1;
            dmaData <= mem[dmaAddr[5:2]];
        end else if (dmaReq) begin
            waitCnt <= waitCnt + 2'h1;
        end
    end
endmodule // hcf_mem_model

// [hcf_front_end_tb.sv]
// hcf_front_end_tb: self-checking bench for the host command FIFO front end.
// assumes hcf_mem_model answers DMA; ce held high, so frozen states go untested.
`timescale 1ns/100ps
module hcf_front_end_tb;
    import hcf_pkg::*;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [13:0]       paddr = 14'h0;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata, dmaAddr, dmaData, cmdEdgeStart, regValue;
    logic              pready, pslverr, dmaReq, dmaAck, dmaIrq, cmdStrobe;
    logic              cmdUseEdge, syncHold, lbWriteInhibit;
    hcf_cmd_t          cmdKind;
    logic              memWritesPending = 1'b0;
    logic [5:0]        regSel = 6'h0;
    logic [1:0]        gap = 2'h0;
    logic [33:0]       apbQ[$];
    logic [34:0]       cmdQ[$];
    logic [33:0]       note;
    logic [34:0]       cn;
    logic [31:0]       lastRd, a, b;
    logic [13:0]       ptr = 14'h0;
    int                n_fail = 0, n_tests = 0, cyc = 0, seed = 66, lastWaits, w;

    always #2 mclk = ~mclk;

    hcf_front_end i_dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dmaReq(dmaReq),
        .dmaAddr(dmaAddr), .dmaAck(dmaAck), .dmaData(dmaData), .dmaIrq(dmaIrq),
        .cmdStrobe(cmdStrobe), .cmdKind(cmdKind), .cmdUseEdge(cmdUseEdge),
        .cmdEdgeStart(cmdEdgeStart), .syncHold(syncHold),
        .memWritesPending(memWritesPending), .lbWriteInhibit(lbWriteInhibit),
        .regSel(regSel), .regValue(regValue));
    hcf_mem_model i_mem (.mclk(mclk), .rst_n(rst_n), .dmaReq(dmaReq), .dmaAddr(dmaAddr),
        .gap(gap), .dmaAck(dmaAck), .dmaData(dmaData));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (apbQ.size() != 0 || cmdQ.size() != 0) n_fail++;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one APB transfer; the note says whether read data is compared
    task automatic apb(input logic wr, input logic [13:0] adr, input logic [31:0] d,
                       input logic err, input logic care);
        apbQ.push_back({care, err, d});
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= adr;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        lastWaits = 0;
        do begin
            @(posedge mclk);
            lastWaits++;
        end while (pready !== 1'b1);
        lastRd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [13:0] adr, input logic [31:0] exp, input logic err);
        apb(1'b0, adr, exp, err, 1'b1);
    endtask

    task automatic wr(input logic [13:0] adr, input logic [31:0] d);
        apb(1'b1, adr, d, 1'b0, 1'b0);
    endtask

    // ascending word addresses through the alias window, wrapping at its top
    task automatic fw(input logic [31:0] d);
        wr(FIFO_LO | ptr, d);
        ptr = (ptr + 14'h4) & 14'h0FFC;
    endtask

    function automatic logic [31:0] hdr(input logic [1:0] f, input logic [13:0] c,
                                        input logic [5:0] id);
        return {f, c, 10'h0, id};
    endfunction

    task automatic basic(input logic [5:0] id, input logic [31:0] v);
        fw(hdr(FMT_BASIC, 14'h0, id));
        fw(v);
    endtask

    // poll the free count until the decoder has emptied the FIFO
    task automatic drain();
        int k;
        k = 0;
        do begin
            apb(1'b0, OFF_FREE, 32'h0, 1'b0, 1'b0);
            k++;
        end while (lastRd !== 32'(FIFO_DEPTH) && k < 100);
        chk("drain", lastRd, 32'(FIFO_DEPTH));
    endtask

    task automatic rchk(input logic [5:0] id, input logic [31:0] exp);
        regSel <= id;
        repeat (2) @(posedge mclk);
        chk("register", regValue, exp);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    // oldest note is taken whenever an APB answer or a command appears
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = apbQ.pop_front();
            if (note[33]) chk("prdata", prdata, note[31:0]);
            chk("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
        end
        if (cmdStrobe === 1'b1) begin
            cn = cmdQ.pop_front();
            chk("cmd kind", {29'h0, cmdUseEdge, cmdKind}, {29'h0, cn[34:32]});
            chk("edge start", cmdEdgeStart, cn[31:0]);
        end
    end

    // hang guard well above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(OFF_CTRL, 32'h0, 1'b0);
        rd(OFF_FREE, 32'(FIFO_DEPTH), 1'b0);
        rd(OFF_STATUS, {24'h0, DEC_HEAD, DMA_IDLE, 2'h0}, 1'b0);
        rd(14'h0100, 32'h0, 1'b1);
        rd(14'h0002, 32'h0, 1'b1);
        rd(14'h2A00, 32'h0, 1'b0);
        done("reset");
        // formats, starting near the top of the alias window so it wraps
        ptr = 14'h0FF8;
        a = $random(seed);
        basic(6'h05, a);
        fw(hdr(FMT_INDEX, 14'h0, 6'h02));
        for (int k = 0; k < 4; k++) fw(a + 32'(k));
        basic(6'h0E, 32'h0);
        fw(hdr(FMT_HOLD, 14'h3, 6'h0D));
        for (int k = 0; k < 3; k++) fw(a ^ 32'(k));
        drain();
        rchk(6'h05, a);
        for (int k = 0; k < 4; k++) rchk(6'(8 + k), a + 32'(k));
        rchk(6'h0D, a ^ 32'h2);
        rchk(6'h0E, 32'h0);
        done("formats");
        // render latches the start value; continues keep it after a reload
        a = $random(seed);
        b = $random(seed);
        basic(ID_START, a);
        cmdQ.push_back({1'b0, CMD_RENDER, a});
        basic(ID_RENDER, 32'h0);
        basic(6'h0C, b);
        cmdQ.push_back({1'b0, CMD_RENDER, a});
        basic(ID_RENDER, 32'h0);
        basic(ID_START, b);
        cmdQ.push_back({1'b1, CMD_LINE, a});
        basic(ID_LINE, 32'h0);
        cmdQ.push_back({1'b1, CMD_DOM, a});
        basic(ID_DOM, 32'h0);
        drain();
        rchk(ID_START, b);
        chk("cmd left", 32'(cmdQ.size()), 32'h0);
        done("commands");
        // DMA with a prompt and then a slow memory
        for (int g = 0; g < 2; g++) begin
            a = $random(seed);
            i_mem.mem[0] = hdr(FMT_BASIC, 14'h0, 6'h34);
            i_mem.mem[1] = a;
            i_mem.mem[2] = hdr(FMT_BASIC, 14'h0, 6'h35);
            i_mem.mem[3] = ~a;
            gap <= 2'(3 * g);
            wr(OFF_DMA_ADR, 32'h0);
            wr(OFF_DMA_CNT, 32'h4);
            w = 0;
            while (dmaIrq !== 1'b1 && w < 500) begin
                @(posedge mclk);
                w++;
            end
            chk("dma irq", {31'h0, dmaIrq}, 32'h1);
            rd(OFF_DMA_ADR, 32'h10, 1'b0);
            rd(OFF_DMA_CNT, 32'h0, 1'b0);
            drain();
            rchk(6'h34, a);
            rchk(6'h35, ~a);
            wr(OFF_DMA_CNT, 32'h0);
            @(posedge mclk);
            chk("dma irq clear", {31'h0, dmaIrq}, 32'h0);
        end
        done("dma");
        // sync parks the decoder; the full FIFO first drops, then stalls the bus
        basic(6'h31, 32'h0);
        memWritesPending <= 1'b1;
        basic(ID_SYNC, 32'h0);
        w = 0;
        while (syncHold !== 1'b1 && w < 50) begin
            @(posedge mclk);
            w++;
        end
        chk("sync hold", {31'h0, syncHold}, 32'h1);
        for (int k = 0; k < 7; k++) basic(6'h30, 32'(k));
        cmdQ.push_back({1'b0, CMD_RENDER, b});
        basic(ID_RENDER, 32'h0);
        rd(OFF_FREE, 32'h0, 1'b0);
        chk("held cmd", 32'(cmdQ.size()), 32'h1);
        fw(hdr(FMT_BASIC, 14'h0, 6'h31));
        wr(OFF_CTRL, 32'h1);
        fork
            fw(hdr(FMT_BASIC, 14'h0, 6'h32));
            begin
                repeat (20) @(posedge mclk);
                memWritesPending <= 1'b0;
            end
        join
        chk("stall", 32'(lastWaits > 20), 32'h1);
        fw(a);
        drain();
        rchk(6'h30, 32'h6);
        rchk(6'h31, 32'h0);
        rchk(6'h32, a);
        done("full fifo");
        wr(OFF_CTRL, 32'h2);
        repeat (2) @(posedge mclk);
        chk("lb inhibit", {31'h0, lbWriteInhibit}, 32'h1);
        rd(OFF_CTRL, 32'h2, 1'b0);
        done("inhibit");
        wrap_up();
    end
endmodule // hcf_front_end_tb
